// ---- core/pqed_detector.sv ----
// Notes on behaviour
// - Sag flag after programmed half cycles below
// - Sag sets latest phase indicator only
// - Writing sag bit clears flag, indicators
// - Masked sag drives interrupt low one clock later, from the registered flag
// - Sag count write restarts sag counters if a threshold is set
// - Sag compares magnitude; extremes fixed behaviour
// - Thresholds read as words, top byte zero
// - Track voltage and current peaks per window
// - Phase select bits choose monitored phases
// - Window counts crossings of selected phases
// - Window end sets one-hot phase tag
// - Window end sets peak flags, interrupt
// - Peak count write restarts window if a phase is selected
// - Overvoltage sets flag and phase indicator
// - Masked overvoltage drives interrupt low
// - Writing overvoltage bit clears flag, indicators
// - Overcurrent sets flag, indicator, interrupt
// - Writing overcurrent bit clears flag, indicators
// - Overvoltage, overcurrent: zero threshold always, full scale never
module pqed_detector
   import pqed_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic smp_vld_i,
   input wire logic [2:0][SMP_W-1:0] v_smp_i,
   input wire logic [2:0][SMP_W-1:0] i_smp_i,
   input wire logic [2:0] zc_i,
   output logic event_interrupt_n_o
);

   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      logic [31:0] status;
      logic [31:0] mask;
      logic [15:0] phst;
      logic [23:0] sag_thr;
      logic [7:0] sag_cyc;
      logic [7:0] pk_cyc;
      logic [7:0] measurement_mode_register;
      logic [23:0] ov_thr;
      logic [23:0] oc_thr;
      logic [31:0] vpk;
      logic [31:0] ipk;
      logic [2:0][7:0] sag_cnt;
      logic [2:0][23:0] hc_max;
      logic [9:0] pk_cnt;
      logic [23:0] vrun;
      logic [2:0] vtag;
      logic [23:0] irun;
      logic [2:0] itag;
   } pqed_state_s;

   localparam pqed_state_s RST_STATE = '{
      sag_thr: SAG_THR_RST, sag_cyc: SAG_CYC_RST, pk_cyc: PK_CYC_RST,
      measurement_mode_register: MEASUREMENT_MODE_REGISTER_RST, ov_thr: OV_THR_RST, oc_thr: OC_THR_RST,
      default: '0};

   pqed_state_s q;
   pqed_state_s d;
   logic req;
   logic wr_go;
   logic [7:0] reg_adr;
   logic [31:0] wmask;
   logic [31:0] st_clr;
   logic sag_cyc_wr;
   logic pk_cyc_wr;
   logic [2:0] pk_sel;
   logic [2:0] zc_sel;
   logic [9:0] pk_cnt_nx;
   logic [2:0][23:0] vmag;
   logic [2:0][23:0] imag;
   logic [2:0] ov_hit;
   logic [2:0] oc_hit;
   logic [2:0] sag_hit;
   logic [2:0] sag_latest;
   logic pk_end;

   // Magnitude of a two's complement sample, saturating the most negative
   function automatic logic [23:0] mag(input logic [23:0] x);
      logic [23:0] r;
      r = x;
      if (x == MAG_MIN_NEG) begin
         r = MAG_MAX;
      end else if (x[23]) begin
         r = -x;
      end
      return r;
   endfunction : mag

   // Byte-lane merge of a write into a stored word
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [31:0] m);
      return (old & ~m) | (nw & m);
   endfunction : merge

   // Read data for a byte address; unmapped addresses read zero
   function automatic logic [31:0] rd_value(input pqed_state_s s,
                                            input logic [7:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      unique case (a)
         ADR_EVT_STATUS: r = s.status;
         ADR_EVT_MASK: r = s.mask;
         ADR_PH_STATUS: r = {16'h0000, s.phst};
         ADR_SAG_THR: r = {8'h00, s.sag_thr};
         ADR_SAG_CYC: r = {24'h000000, s.sag_cyc};
         ADR_PK_CYC: r = {24'h000000, s.pk_cyc};
         ADR_MEASUREMENT_MODE_REGISTER: r = {24'h000000, s.measurement_mode_register};
         ADR_VOLTAGE_PEAK_VALUE: r = s.vpk;
         ADR_CURRENT_PEAK_VALUE: r = s.ipk;
         ADR_OV_THR: r = {8'h00, s.ov_thr};
         ADR_OC_THR: r = {8'h00, s.oc_thr};
         default: r = 32'h0000_0000;
      endcase
      return r;
   endfunction : rd_value

   // Bus decode; a write lands at the edge where ack is seen
   assign req = cyc_i & stb_i;
   assign wr_go = req & we_i & q.ack;
   assign reg_adr = {adr_i[7:2], 2'b00};
   assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}},
                   {8{sel_i[0]}}};
   assign st_clr = (wr_go && reg_adr == ADR_EVT_STATUS) ?
                   (dat_i & wmask & ST_IMPL) : 32'h0000_0000;
   assign sag_cyc_wr = wr_go && reg_adr == ADR_SAG_CYC && sel_i[0];
   assign pk_cyc_wr = wr_go && reg_adr == ADR_PK_CYC && sel_i[0];

   // Peak window time base from the selected phases' crossings
   assign pk_sel = q.measurement_mode_register[PKSEL_LSB +: 3];
   assign zc_sel = zc_i & pk_sel;
   assign pk_cnt_nx = q.pk_cnt + {9'h000, zc_sel[0]} +
                      {9'h000, zc_sel[1]} + {9'h000, zc_sel[2]};
   assign pk_end = (q.pk_cyc != 8'h00) &&
                   (pk_cnt_nx >= {2'b00, q.pk_cyc});

   // Per-phase magnitudes and instantaneous threshold tests
   for (genvar p = 0; p < 3; p++) begin : g_phase
      assign vmag[p] = mag(v_smp_i[p]);
      assign imag[p] = mag(i_smp_i[p]);
      assign ov_hit[p] = smp_vld_i && (q.ov_thr == 24'h000000 ||
         (q.ov_thr < FULL_SCALE && vmag[p] > q.ov_thr));
      assign oc_hit[p] = smp_vld_i && (q.oc_thr == 24'h000000 ||
         (q.oc_thr < FULL_SCALE && imag[p] > q.oc_thr));
   end

   // Next-state logic for the whole block
   always_comb begin
      logic below;
      logic [8:0] cnt_nx;
      logic [2:0] tag;
      below = 1'b0;
      cnt_nx = 9'h000;
      tag = 3'b000;
      d = q;
      sag_hit = 3'b000;
      sag_latest = 3'b000;
      // Single-cycle ack with registered read data
      d.ack = req & ~q.ack;
      if (req && !q.ack) begin
         d.rdat = rd_value(q, reg_adr);
      end
      // Register writes
      if (wr_go) begin
         unique case (reg_adr)
            ADR_EVT_MASK: d.mask = merge(q.mask, dat_i, wmask);
            ADR_SAG_THR: d.sag_thr = 24'(merge({8'h00, q.sag_thr},
                                        dat_i, wmask));
            ADR_SAG_CYC: d.sag_cyc = 8'(merge({24'h0, q.sag_cyc},
                                        dat_i, wmask));
            ADR_PK_CYC: d.pk_cyc = 8'(merge({24'h0, q.pk_cyc},
                                       dat_i, wmask));
            ADR_MEASUREMENT_MODE_REGISTER: d.measurement_mode_register = 8'(merge({24'h0, q.measurement_mode_register}, dat_i, wmask));
            ADR_OV_THR: d.ov_thr = 24'(merge({8'h00, q.ov_thr},
                                       dat_i, wmask));
            ADR_OC_THR: d.oc_thr = 24'(merge({8'h00, q.oc_thr},
                                       dat_i, wmask));
            default: begin
            end
         endcase
      end
      // Sag: per-phase half-cycle maximum test and run length
      for (int p = 0; p < 3; p++) begin
         below = (q.sag_thr > SAG_NEVER_MAX) &&
                 (q.sag_thr >= FULL_SCALE ||
                  q.hc_max[p] < q.sag_thr);
         cnt_nx = {1'b0, q.sag_cnt[p]} + 9'h001;
         if (zc_i[p]) begin
            d.hc_max[p] = 24'h000000;
            if (!below) begin
               d.sag_cnt[p] = 8'h00;
            end else if (cnt_nx >= {1'b0, q.sag_cyc}) begin
               sag_hit[p] = 1'b1;
               d.sag_cnt[p] = 8'h00;
            end else begin
               d.sag_cnt[p] = cnt_nx[7:0];
            end
         end else if (smp_vld_i && vmag[p] > q.hc_max[p]) begin
            d.hc_max[p] = vmag[p];
         end
         if (sag_hit[p]) begin
            sag_latest = 3'(3'b001 << p);
         end
      end
      // Restart the sag run on a count write while a threshold is programmed
      if (sag_cyc_wr && q.sag_thr != 24'h000000) begin
         d.sag_cnt = '0;
      end
      // Peak tracking over the selected phases
      for (int p = 0; p < 3; p++) begin
         if (smp_vld_i && pk_sel[p]) begin
            if (vmag[p] > d.vrun) begin
               d.vrun = vmag[p];
               d.vtag = 3'(3'b001 << p);
            end
            if (imag[p] > d.irun) begin
               d.irun = imag[p];
               d.itag = 3'(3'b001 << p);
            end
         end
      end
      d.pk_cnt = pk_cnt_nx;
      if (pk_end) begin
         tag = pk_sel & (~pk_sel + 3'b001);
         d.vpk = {5'h00, (d.vtag != 3'b000) ? d.vtag : tag,
                  d.vrun};
         d.ipk = {5'h00, (d.itag != 3'b000) ? d.itag : tag,
                  d.irun};
         d.pk_cnt = 10'h000;
         d.vrun = 24'h000000;
         d.irun = 24'h000000;
         d.vtag = 3'b000;
         d.itag = 3'b000;
      end
      // Restart the window when the count is rewritten with a phase selected
      if (pk_cyc_wr && pk_sel != 3'b000) begin
         d.pk_cnt = 10'h000;
         d.vrun = 24'h000000;
         d.irun = 24'h000000;
         d.vtag = 3'b000;
         d.itag = 3'b000;
      end
      // Write-one-to-clear of flags and their phase indicators
      d.status = q.status & ~st_clr;
      if (st_clr[ST_SAG]) begin
         d.phst[PH_SAG_LSB +: 3] = 3'b000;
      end
      if (st_clr[ST_OV]) begin
         d.phst[PH_OV_LSB +: 3] = 3'b000;
      end
      if (st_clr[ST_OC]) begin
         d.phst[PH_OC_LSB +: 3] = 3'b000;
      end
      // New events win over a clear in the same cycle
      if (sag_hit != 3'b000) begin
         d.status[ST_SAG] = 1'b1;
         d.phst[PH_SAG_LSB +: 3] = sag_latest;
      end
      if (ov_hit != 3'b000) begin
         d.status[ST_OV] = 1'b1;
         d.phst[PH_OV_LSB +: 3] = d.phst[PH_OV_LSB +: 3] | ov_hit;
      end
      if (oc_hit != 3'b000) begin
         d.status[ST_OC] = 1'b1;
         d.phst[PH_OC_LSB +: 3] = d.phst[PH_OC_LSB +: 3] | oc_hit;
      end
      if (pk_end) begin
         d.status[ST_PKI] = 1'b1;
         d.status[ST_PKV] = 1'b1;
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= RST_STATE;
      end else begin
         q <= d;
      end
   end

   // Outputs; interrupt low while any enabled flag stands
   assign ack_o = q.ack;
   assign dat_o = q.rdat;
   assign event_interrupt_n_o = ~|(q.status & q.mask);

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_sag_set_flag: assert property (
      sag_hit != 3'b000 |=> q.status[ST_SAG])
      else $error("sag event did not set the sag flag");
   a_sag_phase_latest: assert property (
      sag_hit != 3'b000 |=> $onehot(q.phst[PH_SAG_LSB +: 3]) &&
         q.phst[PH_SAG_LSB +: 3] == $past(sag_latest))
      else $error("sag phase indicator not the latest phase");
   a_sag_clear_all: assert property (
      st_clr[ST_SAG] && sag_hit == 3'b000 |=>
         !q.status[ST_SAG] && q.phst[PH_SAG_LSB +: 3] == 3'b000)
      else $error("sag clear left flag or indicator set");
   a_sag_irq_low: assert property (
      sag_hit != 3'b000 && q.mask[ST_SAG] && !st_clr[ST_SAG] |=>
         !event_interrupt_n_o)
      else $error("masked sag did not pull interrupt low");
   a_sag_cnt_restart: assert property (
      sag_cyc_wr && q.sag_thr != 24'h000000 |=> q.sag_cnt == '0)
      else $error("sag count write did not restart counters");
   a_sag_low_thr: assert property (
      q.sag_thr <= SAG_NEVER_MAX |-> sag_hit == 3'b000)
      else $error("sag triggered with a zero threshold");
   a_thr_pad_zero: assert property (
      req && !q.ack && reg_adr == ADR_OV_THR |=> q.rdat[31:24] == 8'h00)
      else $error("threshold read upper byte not zero");
   a_peak_tag_one: assert property (
      pk_end && pk_sel != 3'b000 && !pk_cyc_wr |=>
         $onehot(q.vpk[PK_TAG_LSB +: 3]) && $onehot(q.ipk[PK_TAG_LSB +: 3]))
      else $error("peak phase tag not one-hot");
   a_peak_flags: assert property (
      pk_end |=> q.status[ST_PKI] && q.status[ST_PKV])
      else $error("window end did not set peak flags");
   a_pk_restart: assert property (
      pk_cyc_wr && pk_sel != 3'b000 |=> q.pk_cnt == 10'h000)
      else $error("peak count write did not restart window");
   a_ov_set: assert property (
      ov_hit != 3'b000 |=> q.status[ST_OV] &&
         (q.phst[PH_OV_LSB +: 3] & $past(ov_hit)) == $past(ov_hit))
      else $error("overvoltage flag or indicator missing");
   a_oc_irq: assert property (
      oc_hit != 3'b000 && q.mask[ST_OC] |=> !event_interrupt_n_o)
      else $error("masked overcurrent did not pull interrupt low");
   a_oc_zero_thr: assert property (
      smp_vld_i && q.oc_thr == 24'h000000 ##1 q.mask[ST_OC] |->
         !event_interrupt_n_o)
      else $error("zero overcurrent threshold not detected");
   a_ack_pulse: assert property (
      req && !q.ack |=> q.ack ##1 !q.ack)
      else $error("ack not a single pulse after request");

   c_sag_event: cover property (sag_hit != 3'b000 ##1 !event_interrupt_n_o);
   c_peak_window: cover property (pk_end && pk_sel == 3'b011);
   c_ov_clear: cover property (ov_hit != 3'b000 ##[1:20] st_clr[ST_OV]);
   c_set_and_clear: cover property (st_clr[ST_SAG] && sag_hit != 3'b000);

endmodule : pqed_detector

// ---- core/pqed_pkg.sv ----
package pqed_pkg;
   // Sample and address widths
   localparam int SMP_W = 24;
   localparam int ADR_W = 8;
   // Register byte addresses
   localparam logic [7:0] ADR_EVT_STATUS = 8'h00;
   localparam logic [7:0] ADR_EVT_MASK = 8'h04;
   localparam logic [7:0] ADR_PH_STATUS = 8'h08;
   localparam logic [7:0] ADR_SAG_THR = 8'h0C;
   localparam logic [7:0] ADR_SAG_CYC = 8'h10;
   localparam logic [7:0] ADR_PK_CYC = 8'h14;
   localparam logic [7:0] ADR_MEASUREMENT_MODE_REGISTER = 8'h18;
   localparam logic [7:0] ADR_VOLTAGE_PEAK_VALUE = 8'h1C;
   localparam logic [7:0] ADR_CURRENT_PEAK_VALUE = 8'h20;
   localparam logic [7:0] ADR_OV_THR = 8'h24;
   localparam logic [7:0] ADR_OC_THR = 8'h28;
   // Event status and mask bit positions
   localparam int ST_SAG = 16;
   localparam int ST_OC = 17;
   localparam int ST_OV = 18;
   localparam int ST_PKI = 23;
   localparam int ST_PKV = 24;
   localparam logic [31:0] ST_IMPL = 32'h0187_0000;
   // Phase status field positions (three bits each)
   localparam int PH_SAG_LSB = 12;
   localparam int PH_OV_LSB = 9;
   localparam int PH_OC_LSB = 3;
   // Peak register layout
   localparam int PK_TAG_LSB = 24;
   // Peak phase select field in the measurement mode register
   localparam int PKSEL_LSB = 2;
   // Full scale of the filtered channel magnitude
   localparam logic [23:0] FULL_SCALE = 24'h5A7540;
   localparam logic [23:0] SAG_NEVER_MAX = 24'h000001;
   localparam logic [23:0] MAG_MAX = 24'h7FFFFF;
   localparam logic [23:0] MAG_MIN_NEG = 24'h800000;
   // Reset values
   localparam logic [23:0] SAG_THR_RST = 24'h000000;
   localparam logic [7:0] SAG_CYC_RST = 8'h01;
   localparam logic [7:0] PK_CYC_RST = 8'h01;
   localparam logic [7:0] MEASUREMENT_MODE_REGISTER_RST = 8'h00;
   localparam logic [23:0] OV_THR_RST = 24'h5A7540;
   localparam logic [23:0] OC_THR_RST = 24'h5A7540;
endpackage : pqed_pkg

// ---- verif/pqed_host.sv ----
module pqed_host
   import pqed_pkg::*;
(
   input wire logic clk_i,
   input wire logic ack_i,
   input wire logic [31:0] dat_i,
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [ADR_W-1:0] adr_o,
   output logic [3:0] sel_o,
   output logic [31:0] dat_o,
   output logic tmo_o
);
   timeunit 1ns;
   timeprecision 1ns;

   // Bus idle until the first transfer
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = '0;
      sel_o = 4'h0;
      dat_o = 32'h0000_0000;
      tmo_o = 1'b0;
   end

   // One classic cycle, held until ack is sampled high
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
      int n = 0;
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      sel_o <= 4'hF;
      dat_o <= wd;
      // Ack and read data are taken at the same rising edge
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_i !== 1'b1 && n < 64);
      if (ack_i !== 1'b1) tmo_o <= 1'b1;
      rd = dat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
   endtask : xfer

   // Plain word write
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      xfer(1'b1, a, d, x);
   endtask : wr

   // Plain word read
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      xfer(1'b0, a, 32'h0000_0000, d);
   endtask : rd

   // A zero count is never sent to the device
   task automatic set_sag_count(input logic [7:0] n);
      if (n != 8'h00) wr(ADR_SAG_CYC, {24'h000000, n});
   endtask : set_sag_count

   // Event service: status, then detail register, then clear
   task automatic service(input logic [7:0] det, input int b,
                          output logic [31:0] st, output logic [31:0] dv);
      rd(ADR_EVT_STATUS, st);
      rd(det, dv);
      wr(ADR_EVT_STATUS, 32'h0000_0001 << b);
   endtask : service
endmodule : pqed_host

// ---- verif/testbench.sv ----
module testbench;
   import pqed_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc;
   logic stb;
   logic we;
   logic [ADR_W-1:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic ack;
   logic tmo;
   logic irq_n;
   logic smp_vld = 1'b0;
   logic [2:0][SMP_W-1:0] v_smp = '0;
   logic [2:0][SMP_W-1:0] i_smp = '0;
   logic [2:0] zc = 3'h0;
   logic [31:0] st;
   logic [31:0] dv;
   int failures = 0;
   int check_count = 0;

   // Bench clock, 40 ns period
   always #20 clk_i = ~clk_i;

   pqed_detector i_pqed_detector (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
      .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
      .dat_o(rdat), .ack_o(ack), .smp_vld_i(smp_vld), .v_smp_i(v_smp),
      .i_smp_i(i_smp), .zc_i(zc), .event_interrupt_n_o(irq_n));

   pqed_host i_pqed_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat),
      .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
      .dat_o(wdat), .tmo_o(tmo));

   // Verdict and end of run
   task automatic stop_test();
      if (failures == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test

   // A bus cycle that never got its ack ends the run
   always @(posedge tmo) begin
      failures++;
      stop_test();
   end

   // Word comparison
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t word %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Interrupt pin comparison, once the event has settled
   task automatic chk_irq(input logic exp);
      repeat (3) @(negedge clk_i);
      check_count++;
      if (irq_n !== exp) begin
         failures++;
         $display("ERROR %0t interrupt %b expected %b", $time, irq_n, exp);
      end
   endtask : chk_irq

   // Register access shorthands
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_pqed_host.wr(a, d);
   endtask : wr

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      i_pqed_host.rd(a, d);
      chk(d, exp);
   endtask : rchk

   // One sample strobe with voltage and current of all phases
   task automatic smp(input logic [2:0][23:0] v, input logic [2:0][23:0] i);
      @(posedge clk_i);
      smp_vld <= 1'b1;
      v_smp <= v;
      i_smp <= i;
      @(posedge clk_i);
      smp_vld <= 1'b0;
   endtask : smp

   // One zero-crossing pulse on the given phases
   task automatic zcp(input logic [2:0] z);
      @(posedge clk_i);
      zc <= z;
      @(posedge clk_i);
      zc <= 3'h0;
      repeat (2) @(posedge clk_i);
   endtask : zcp

   // Main sequence
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      rchk(ADR_EVT_STATUS, 32'h0000_0000);
      rchk(ADR_SAG_CYC, 32'h0000_0001);
      rchk(ADR_OV_THR, {8'h00, FULL_SCALE});
      rchk(8'h3C, 32'h0000_0000);
      wr(ADR_OV_THR, 32'hFF00_0100);
      rchk(ADR_OV_THR, 32'h0000_0100);
      wr(ADR_EVT_MASK, ST_IMPL);
      // Overvoltage on a negative phase B sample
      smp({24'h000000, 24'hFFFE00, 24'h000000}, '0);
      chk_irq(1'b0);
      rchk(ADR_EVT_STATUS, 32'h0004_0000);
      rchk(ADR_PH_STATUS, 32'h0000_0400);
      wr(ADR_EVT_STATUS, 32'h0004_0000);
      rchk(ADR_EVT_STATUS, 32'h0000_0000);
      rchk(ADR_PH_STATUS, 32'h0000_0000);
      chk_irq(1'b1);
      // Overcurrent, zero threshold first, then phase A
      wr(ADR_OC_THR, 32'h0000_0000);
      smp('0, '0);
      chk_irq(1'b0);
      rchk(ADR_EVT_STATUS, 32'h0002_0000);
      wr(ADR_OC_THR, 32'h0000_0010);
      wr(ADR_EVT_STATUS, 32'h0002_0000);
      rchk(ADR_EVT_STATUS, 32'h0000_0000);
      rchk(ADR_PH_STATUS, 32'h0000_0000);
      chk_irq(1'b1);
      smp('0, {24'h000000, 24'h000000, 24'h000020});
      chk_irq(1'b0);
      i_pqed_host.service(ADR_PH_STATUS, ST_OC, st, dv);
      chk(st, 32'h0002_0000);
      chk(dv, 32'h0000_0008);
      wr(ADR_OV_THR, {8'h00, FULL_SCALE});
      wr(ADR_OC_THR, {8'h00, FULL_SCALE});
      // Peak window over phases A and B, phase C ignored
      wr(ADR_MEASUREMENT_MODE_REGISTER, 32'h0000_000C);
      wr(ADR_PK_CYC, 32'h0000_0002);
      smp({24'h007000, 24'h000100, 24'h000400},
          {24'h007000, 24'hFFFD00, 24'h000100});
      zcp(3'h1);
      rchk(ADR_EVT_STATUS, 32'h0000_0000);
      zcp(3'h2);
      chk_irq(1'b0);
      i_pqed_host.service(ADR_CURRENT_PEAK_VALUE, ST_PKI, st, dv);
      chk(st, 32'h0180_0000);
      chk(dv, 32'h0200_0300);
      rchk(ADR_VOLTAGE_PEAK_VALUE, 32'h0100_0400);
      smp({24'h000000, 24'h000600, 24'h000050}, '0);
      zcp(3'h1);
      zcp(3'h2);
      rchk(ADR_VOLTAGE_PEAK_VALUE, 32'h0200_0600);
      wr(ADR_MEASUREMENT_MODE_REGISTER, 32'h0000_0000);
      wr(ADR_EVT_STATUS, 32'h0180_0000);
      chk_irq(1'b1);
      // Sag on phase B, then on phase A; crossings first clear the maxima
      zcp(3'h7);
      wr(ADR_SAG_THR, 32'hFF00_1000);
      rchk(ADR_SAG_THR, 32'h0000_1000);
      i_pqed_host.set_sag_count(8'h02);
      smp({3{24'h000010}}, '0);
      zcp(3'h2);
      rchk(ADR_EVT_STATUS, 32'h0000_0000);
      smp({3{24'h000010}}, '0);
      zcp(3'h2);
      chk_irq(1'b0);
      rchk(ADR_EVT_STATUS, 32'h0001_0000);
      rchk(ADR_PH_STATUS, 32'h0000_2000);
      repeat (2) begin
         smp({3{24'h000010}}, '0);
         zcp(3'h1);
      end
      i_pqed_host.service(ADR_PH_STATUS, ST_SAG, st, dv);
      chk(dv, 32'h0000_1000);
      rchk(ADR_EVT_STATUS, 32'h0000_0000);
      rchk(ADR_PH_STATUS, 32'h0000_0000);
      chk_irq(1'b1);
      // Threshold of one never reports a sag
      wr(ADR_SAG_THR, 32'h0000_0001);
      repeat (2) begin
         smp({3{24'h000000}}, '0);
         zcp(3'h2);
      end
      rchk(ADR_EVT_STATUS, 32'h0000_0000);
      stop_test();
   end
endmodule : testbench
